// *** include/rts_pkg.sv ***
package rts_pkg;
   // register byte addresses
   localparam logic [31:0] OFS_BASE_SNAP = 32'h4000001c;
   localparam logic [31:0] OFS_USEC = 32'h40000020;
   localparam logic [31:0] OFS_ADDR_LOW = 32'h40000024;
   localparam logic [31:0] OFS_ADDR_HIGH = 32'h40000028;
   localparam logic [31:0] OFS_RX_PTR = 32'h4000002c;
   localparam logic [31:0] OFS_SLEEP_CTL = 32'h40000030;
   localparam logic [31:0] OFS_SLEEP_SET = 32'h40000034;
   localparam logic [31:0] OFS_SLEEP_MEAS = 32'h40000038;
   localparam logic [31:0] OFS_IRQ_STATUS = 32'h40000060;
   localparam logic [31:0] OFS_IRQ_MASK = 32'h40000064;
   localparam logic [31:0] OFS_SAMPLE = 32'h40000068;

   // field widths and positions
   localparam int BASE_W = 27;
   localparam int USEC_W = 10;
   localparam int ADDR_HIGH_W = 16;
   localparam int ADDR_TYPE_BIT = 16;
   localparam int RX_PTR_W = 14;
   localparam int EXT_DIS_BIT = 31;
   localparam int STAT_BIT = 15;
   localparam int SOFT_WAKE_BIT = 4;
   localparam int CORR_EN_BIT = 3;
   localparam int SLEEP_REQ_BIT = 2;
   localparam int SAMPLE_BIT = 0;
   localparam int IRQ_W = 3;
   localparam int EV_SLEEP_ENTER = 0;
   localparam int EV_WOKE = 1;
   localparam int EV_BASE_TICK = 2;

   // reset word and full wake interrupt enable
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   localparam logic [1:0] WAKE_IRQ_ALL = 2'h3;

   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int USEC_NS = 1000;
   localparam int CYC_PER_USEC = USEC_NS / CLK_PERIOD_NS;
   localparam int BASE_PERIOD_US = 625;
   localparam logic [4:0] USEC_DIV_LAST = 5'(CYC_PER_USEC - 1);
   localparam logic [USEC_W-1:0] FINE_LAST = USEC_W'(BASE_PERIOD_US - 1);

   typedef enum logic [1:0] {
      ST_ACTIVE,
      ST_DEEP,
      ST_HALTED
   } rts_state_t;

   typedef struct packed {
      logic ext_wake_disable;
      logic sleep_request;
      logic [1:0] wake_irq_enable;
   } rts_sleep_ctl_t;
endpackage

// *** design/rts_regs.sv ***
// The APB slave port was left to the implementer.
module rts_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic lp_clk,
   input wire logic ext_wake,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic deep_sleep_active,
   output logic lowpower_wake_interrupt
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [rts_pkg::BASE_W-1:0] base_period_value;
   logic [rts_pkg::BASE_W-1:0] base_period_snapshot;
   logic [rts_pkg::USEC_W-1:0] microsecond_value;
   logic [4:0] usec_div;
   logic [31:0] addr_low_bits;
   logic [rts_pkg::ADDR_HIGH_W-1:0] addr_high_bits;
   logic addr_type_private;
   logic [rts_pkg::RX_PTR_W-1:0] rx_list_start;
   rts_pkg::rts_sleep_ctl_t sleep_ctl;
   logic [31:0] sleep_duration_setting;
   logic [31:0] measured_sleep_duration;
   logic [rts_pkg::IRQ_W-1:0] irq_status;
   logic [rts_pkg::IRQ_W-1:0] irq_mask;
   rts_pkg::rts_state_t state;
   rts_pkg::rts_state_t next_state;
   logic lp_meta, lp_sync, lp_prev;
   logic wake_meta, wake_sync;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire logic done = psel & penable & pready;
   wire logic wr = done & pwrite;
   wire logic rd = done & ~pwrite;
   wire logic hit_base = paddr == rts_pkg::OFS_BASE_SNAP;
   wire logic hit_usec = paddr == rts_pkg::OFS_USEC;
   wire logic hit_alow = paddr == rts_pkg::OFS_ADDR_LOW;
   wire logic hit_ahigh = paddr == rts_pkg::OFS_ADDR_HIGH;
   wire logic hit_rx = paddr == rts_pkg::OFS_RX_PTR;
   wire logic hit_ctl = paddr == rts_pkg::OFS_SLEEP_CTL;
   wire logic hit_set = paddr == rts_pkg::OFS_SLEEP_SET;
   wire logic hit_meas = paddr == rts_pkg::OFS_SLEEP_MEAS;
   wire logic hit_ist = paddr == rts_pkg::OFS_IRQ_STATUS;
   wire logic hit_imask = paddr == rts_pkg::OFS_IRQ_MASK;
   wire logic hit_sample_trigger = paddr == rts_pkg::OFS_SAMPLE;
   wire logic mapped = hit_base | hit_usec | hit_alow | hit_ahigh | hit_rx | hit_ctl
                       | hit_set | hit_meas | hit_ist | hit_imask | hit_sample_trigger;

   // write strobes; a write to a read-only or unmapped word is dropped
   wire logic wr_ctl = wr & hit_ctl;
   wire logic wr_sample = wr & hit_sample_trigger & pwdata[rts_pkg::SAMPLE_BIT];
   wire logic soft_wake = wr_ctl & pwdata[rts_pkg::SOFT_WAKE_BIT];
   wire logic corr_write = wr_ctl & pwdata[rts_pkg::CORR_EN_BIT];

   // read data; reserved bits and self-clearing bits come back as zero
   wire logic [31:0] ctl_word = {sleep_ctl.ext_wake_disable, 15'h0000, deep_sleep_active, 10'h000,
                                 2'h0, sleep_ctl.sleep_request, sleep_ctl.wake_irq_enable};
   wire logic [31:0] rd_word =
      hit_base ? {5'h00, base_period_snapshot} :
      hit_usec ? {22'h000000, microsecond_value} :
      hit_alow ? addr_low_bits :
      hit_ahigh ? {15'h0000, addr_type_private, addr_high_bits} :
      hit_rx ? {18'h00000, rx_list_start} :
      hit_ctl ? ctl_word :
      hit_set ? sleep_duration_setting :
      hit_meas ? measured_sleep_duration :
      hit_ist ? {29'h00000000, irq_status} :
      hit_imask ? {29'h00000000, irq_mask} :
      rts_pkg::RESET_WORD;

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= rts_pkg::RESET_WORD;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         prdata <= (psel & penable & ~pready & ~pwrite) ? rd_word : rts_pkg::RESET_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the low-power clock is sampled, not used as a clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lp_meta <= 1'b0;
         lp_sync <= 1'b0;
         lp_prev <= 1'b0;
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
      end else begin
         lp_meta <= lp_clk;
         lp_sync <= lp_meta;
         lp_prev <= lp_sync;
         wake_meta <= ext_wake;
         wake_sync <= wake_meta;
      end
   end

   wire logic lp_tick = lp_sync & ~lp_prev;

   ////////////////////////////////////////////////////////////////////////////
   // timebase: counters freeze in sleep and until correction is written
   wire logic count_en = state == rts_pkg::ST_ACTIVE;
   wire logic us_tick = count_en & (usec_div == rts_pkg::USEC_DIV_LAST);
   wire logic fine_wrap = us_tick & (microsecond_value == rts_pkg::FINE_LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usec_div <= 5'h00;
         microsecond_value <= '0;
         base_period_value <= '0;
      end else if (count_en) begin
         usec_div <= us_tick ? 5'h00 : usec_div + 5'h01;
         if (us_tick) begin
            microsecond_value <= fine_wrap ? '0 : microsecond_value + 10'h001;
         end
         if (fine_wrap) begin
            base_period_value <= base_period_value + 27'h0000001;
         end
      end
   end

   // snapshot only on trigger; software sees a stable value between samples
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_period_snapshot <= '0;
      end else if (wr_sample) begin
         base_period_snapshot <= base_period_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // plain read-write registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_low_bits <= rts_pkg::RESET_WORD;
         addr_high_bits <= '0;
         addr_type_private <= 1'b0;
         rx_list_start <= '0;
         sleep_duration_setting <= rts_pkg::RESET_WORD;
         irq_mask <= '0;
      end else if (wr) begin
         if (hit_alow) begin
            addr_low_bits <= pwdata;
         end
         if (hit_ahigh) begin
            addr_high_bits <= pwdata[rts_pkg::ADDR_HIGH_W-1:0];
            addr_type_private <= pwdata[rts_pkg::ADDR_TYPE_BIT];
         end
         if (hit_rx) begin
            rx_list_start <= pwdata[rts_pkg::RX_PTR_W-1:0];
         end
         if (hit_set) begin
            sleep_duration_setting <= pwdata;
         end
         if (hit_imask) begin
            irq_mask <= pwdata[rts_pkg::IRQ_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sleep sequencing
   wire logic ext_wake_ok = wake_sync & ~sleep_ctl.ext_wake_disable;
   wire logic [31:0] meas_inc = measured_sleep_duration + 32'h00000001;
   wire logic time_up = lp_tick & (sleep_duration_setting != 32'h00000000)
                        & (meas_inc >= sleep_duration_setting);
   wire logic wake_now = soft_wake | ext_wake_ok | time_up;
   wire logic stat_fall = (state == rts_pkg::ST_DEEP) & (next_state != rts_pkg::ST_DEEP);

   always_comb begin
      next_state = state;
      case (state)
         rts_pkg::ST_ACTIVE: begin
            // entry waits for a low-power edge so the mux switch is clean
            if (sleep_ctl.sleep_request && lp_tick) begin
               next_state = rts_pkg::ST_DEEP;
            end
         end
         rts_pkg::ST_DEEP: begin
            if (wake_now) begin
               next_state = rts_pkg::ST_HALTED;
            end
         end
         rts_pkg::ST_HALTED: begin
            if (corr_write) begin
               next_state = rts_pkg::ST_ACTIVE;
            end
         end
         default: begin
            next_state = rts_pkg::ST_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= rts_pkg::ST_ACTIVE;
         deep_sleep_active <= 1'b0;
      end else begin
         state <= next_state;
         deep_sleep_active <= next_state == rts_pkg::ST_DEEP;
      end
   end

   // duration counter restarts at entry and runs on low-power edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         measured_sleep_duration <= rts_pkg::RESET_WORD;
      end else if (state == rts_pkg::ST_ACTIVE && next_state == rts_pkg::ST_DEEP) begin
         measured_sleep_duration <= rts_pkg::RESET_WORD;
      end else if (state == rts_pkg::ST_DEEP && lp_tick) begin
         measured_sleep_duration <= meas_inc;
      end
   end

   // control word; a software write in the same cycle beats the auto-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_ctl <= '0;
      end else if (wr_ctl) begin
         sleep_ctl.ext_wake_disable <= pwdata[rts_pkg::EXT_DIS_BIT];
         sleep_ctl.sleep_request <= pwdata[rts_pkg::SLEEP_REQ_BIT];
         sleep_ctl.wake_irq_enable <= pwdata[1:0];
      end else if (stat_fall) begin
         sleep_ctl.sleep_request <= 1'b0;
      end
   end

   // wake interrupt raised at wake if fully enabled, dropped once counters resume
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lowpower_wake_interrupt <= 1'b0;
      end else if (stat_fall && sleep_ctl.wake_irq_enable == rts_pkg::WAKE_IRQ_ALL) begin
         lowpower_wake_interrupt <= 1'b1;
      end else if (corr_write) begin
         lowpower_wake_interrupt <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky events; a read clears only the bits that its data returned
   // prdata was captured one cycle before the clear, so a bit set in between must survive
   wire logic [rts_pkg::IRQ_W-1:0] events = {fine_wrap & (base_period_value[0] | 1'b1), stat_fall,
                                             state == rts_pkg::ST_ACTIVE && next_state == rts_pkg::ST_DEEP};
   wire logic [rts_pkg::IRQ_W-1:0] kept_status = irq_status & ~prdata[rts_pkg::IRQ_W-1:0];
   wire logic [rts_pkg::IRQ_W-1:0] next_status = (rd & hit_ist) ? (kept_status | events)
                                                                 : (irq_status | events);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
         irq <= 1'b0;
      end else begin
         irq_status <= next_status;
         irq <= |(next_status & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_snapshot;
      @(posedge pclk) disable iff (!presetn)
      wr_sample |=> base_period_snapshot == $past(base_period_value);
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("snapshot missed sampled base count");

   property p_usec_step;
      @(posedge pclk) disable iff (!presetn)
      us_tick && !fine_wrap |=> microsecond_value == $past(microsecond_value) + 10'h001;
   endproperty
   a_usec_step: assert property (p_usec_step) else $error("microsecond counter did not step");

   // helper for the tick spacing check: counting cycles since the last tick
   // kept apart from the divider so a broken divider cannot hide itself
   logic [4:0] chk_gap;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chk_gap <= 5'h00;
      end else if (us_tick) begin
         chk_gap <= 5'h00;
      end else if (count_en) begin
         chk_gap <= chk_gap + 5'h01;
      end
   end

   property p_usec_rate;
      @(posedge pclk) disable iff (!presetn)
      count_en |-> (us_tick == (chk_gap == rts_pkg::USEC_DIV_LAST));
   endproperty
   a_usec_rate: assert property (p_usec_rate) else $error("microsecond tick spacing wrong");

   property p_addr_low;
      @(posedge pclk) disable iff (!presetn)
      wr && hit_alow |=> addr_low_bits == $past(pwdata);
   endproperty
   a_addr_low: assert property (p_addr_low) else $error("low address write lost");

   property p_addr_high;
      @(posedge pclk) disable iff (!presetn)
      wr && hit_ahigh |=> {addr_type_private, addr_high_bits} == $past(pwdata[16:0]);
   endproperty
   a_addr_high: assert property (p_addr_high) else $error("high address or type write lost");

   property p_rx_ptr;
      @(posedge pclk) disable iff (!presetn)
      wr && hit_rx |=> rx_list_start == $past(pwdata[13:0]);
   endproperty
   a_rx_ptr: assert property (p_rx_ptr) else $error("rx pointer write lost");

   property p_ext_blocked;
      @(posedge pclk) disable iff (!presetn)
      state == rts_pkg::ST_DEEP && sleep_ctl.ext_wake_disable && !soft_wake && !time_up
      |=> deep_sleep_active;
   endproperty
   a_ext_blocked: assert property (p_ext_blocked) else $error("woke while external wake disabled");

   property p_soft_wake;
      @(posedge pclk) disable iff (!presetn)
      state == rts_pkg::ST_DEEP && soft_wake |=> !deep_sleep_active ##1 !deep_sleep_active;
   endproperty
   a_soft_wake: assert property (p_soft_wake) else $error("soft wake ignored");

   property p_corr;
      @(posedge pclk) disable iff (!presetn)
      state == rts_pkg::ST_HALTED && corr_write |=> count_en;
   endproperty
   a_corr: assert property (p_corr) else $error("counters not restarted");

   property p_req_clear;
      @(posedge pclk) disable iff (!presetn)
      $fell(deep_sleep_active) && !$past(wr_ctl) |-> !sleep_ctl.sleep_request;
   endproperty
   a_req_clear: assert property (p_req_clear) else $error("sleep request not cleared");

   property p_meas;
      @(posedge pclk) disable iff (!presetn)
      state == rts_pkg::ST_DEEP && lp_tick |=> measured_sleep_duration == $past(meas_inc);
   endproperty
   a_meas: assert property (p_meas) else $error("sleep duration not counted");

   property p_reserved;
      @(posedge pclk) disable iff (!presetn)
      pready && !pwrite && hit_ahigh |-> prdata[31:17] == 15'h0000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

endmodule

// *** test/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_CTL = rts_pkg::OFS_SLEEP_CTL;
   localparam logic [31:0] A_US = rts_pkg::OFS_USEC;
   localparam logic [31:0] A_ST = rts_pkg::OFS_IRQ_STATUS;
   localparam logic [31:0] A_MSK = rts_pkg::OFS_IRQ_MASK;
   localparam logic [31:0] A_MEAS = rts_pkg::OFS_SLEEP_MEAS;
   logic pclk, presetn, psel, penable, pwrite, lp_clk, ext_wake;
   logic [31:0] paddr, pwdata, prdata, rd, v0;
   logic pready, pslverr, irq, deep_sleep_active, lowpower_wake_interrupt, err;
   int miscompares = 0;
   int comparisons = 0;

   rts_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .lp_clk(lp_clk), .ext_wake(ext_wake), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .deep_sleep_active(deep_sleep_active),
      .lowpower_wake_interrupt(lowpower_wake_interrupt));

   ////////////////////////////////////////////////////////////
   // clocks: low-power pin is slow so the 2 ff sync sees every edge
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      lp_clk = 1'b0;
      forever begin
         repeat (8) @(posedge pclk);
         lp_clk <= ~lp_clk;
      end
   end

   task automatic wrap_up();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   // range check, unknown never passes
   task automatic check_rng(input logic [31:0] got, input int lo, input int hi, input string what);
      comparisons++;
      if ($isunknown(got) || got < lo || got > hi) begin
         miscompares++;
         $display("[ERR] %0t %s: got %h outside %0d..%0d", $time, what, got, lo, hi);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d = 32'h0);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         check(1'b0, 1'b1, "pready timeout");
         wrap_up();
      end
   endtask

   task automatic wait_deep(input logic v, input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(posedge pclk);
         if (deep_sleep_active === v) break;
      end
      if (n == lim) begin
         check(deep_sleep_active, v, "deep sleep wait timeout");
         wrap_up();
      end
   endtask

   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] al[8] = '{rts_pkg::OFS_BASE_SNAP, rts_pkg::OFS_ADDR_LOW, rts_pkg::OFS_ADDR_HIGH,
         rts_pkg::OFS_RX_PTR, A_CTL, rts_pkg::OFS_SLEEP_SET, A_MEAS, A_MSK};
      foreach (al[i]) begin
         apb(1'b0, al[i]);
         check(rd, rts_pkg::RESET_WORD, "reset value");
      end
      check({29'h0, irq, deep_sleep_active, lowpower_wake_interrupt}, 32'h0, "outputs after reset");
      $display("t_reset done");
   endtask

   task automatic t_regs();
      apb(1'b1, rts_pkg::OFS_ADDR_LOW, 32'hffffffff);
      apb(1'b0, rts_pkg::OFS_ADDR_LOW);
      check(rd, 32'hffffffff, "addr low");
      apb(1'b1, rts_pkg::OFS_ADDR_HIGH, 32'hffffffff);
      apb(1'b0, rts_pkg::OFS_ADDR_HIGH);
      check(rd, 32'h0001ffff, "addr high private");
      apb(1'b1, rts_pkg::OFS_ADDR_HIGH, 32'h0000a5c3);
      apb(1'b0, rts_pkg::OFS_ADDR_HIGH);
      check(rd, 32'h0000a5c3, "addr high public");
      apb(1'b1, rts_pkg::OFS_RX_PTR, 32'hffffffff);
      apb(1'b0, rts_pkg::OFS_RX_PTR);
      check(rd, 32'h00003fff, "rx pointer");
      apb(1'b1, rts_pkg::OFS_BASE_SNAP, 32'hffffffff);
      apb(1'b0, rts_pkg::OFS_BASE_SNAP);
      check(rd, 32'h0, "snapshot ignores write");
      // wake and correction while active must do nothing
      apb(1'b1, A_CTL, 32'h7ffffffb);
      apb(1'b0, A_CTL);
      check(rd, 32'h3, "ctl reserved and strobes");
      check(deep_sleep_active, 1'b0, "still active");
      apb(1'b0, 32'h40000070);
      check({31'h0, err}, 32'h1, "unmapped read error");
      check(rd, 32'h0, "unmapped read data");
      $display("t_regs done");
   endtask

   task automatic t_fine();
      apb(1'b0, A_US);
      v0 = rd;
      check(rd & 32'hfffffc00, 32'h0, "usec upper bits");
      repeat (97) @(posedge pclk);
      apb(1'b0, A_US);
      check_rng((rd[9:0] + 10'd625 - v0[9:0]) % 625, 3, 5, "usec advance");
      $display("t_fine done");
   endtask

   task automatic t_base_irq();
      apb(1'b0, A_ST);
      apb(1'b1, rts_pkg::OFS_SAMPLE, 32'h1);
      apb(1'b0, rts_pkg::OFS_BASE_SNAP);
      v0 = rd;
      repeat (15700) @(posedge pclk);
      apb(1'b0, rts_pkg::OFS_BASE_SNAP);
      check(rd, v0, "snapshot holds without trigger");
      check(irq, 1'b0, "masked tick");
      apb(1'b1, rts_pkg::OFS_SAMPLE, 32'h1);
      apb(1'b0, rts_pkg::OFS_BASE_SNAP);
      check_rng(rd - v0, 1, 2, "snapshot refreshed");
      apb(1'b1, A_MSK, 32'h4);
      repeat (3) @(posedge pclk);
      check(irq, 1'b1, "unmasked tick raises irq");
      apb(1'b0, A_ST);
      check(rd & 32'h4, 32'h4, "tick status");
      apb(1'b0, A_ST);
      check(rd & 32'h4, 32'h0, "status cleared by read");
      check(irq, 1'b0, "irq drops");
      apb(1'b1, A_MSK, 32'h3);
      $display("t_base_irq done");
   endtask

   ////////////////////////////////////////////////////////////
   task automatic t_sleep_soft();
      apb(1'b1, A_CTL, 32'h7);
      wait_deep(1'b1, 100);
      apb(1'b0, A_CTL);
      check(rd, 32'h00008007, "ctl in deep sleep");
      apb(1'b0, A_ST);
      check(rd & 32'h1, 32'h1, "entry status");
      apb(1'b0, A_US);
      v0 = rd;
      repeat (200) @(posedge pclk);
      check(deep_sleep_active, 1'b1, "zero duration stays asleep");
      apb(1'b0, A_US);
      check(rd, v0, "usec frozen in sleep");
      apb(1'b0, A_MEAS);
      check_rng(rd, 1, 40, "measured counts");
      apb(1'b1, A_CTL, 32'h13);
      wait_deep(1'b0, 10);
      apb(1'b0, A_CTL);
      check(rd, 32'h3, "wake bit reads zero");
      check(lowpower_wake_interrupt, 1'b1, "wake interrupt");
      apb(1'b0, A_US);
      v0 = rd;
      repeat (60) @(posedge pclk);
      apb(1'b0, A_US);
      check(rd, v0, "usec held until correction");
      apb(1'b1, A_CTL, 32'hb);
      apb(1'b0, A_CTL);
      check(rd, 32'h3, "correction reads zero");
      check(lowpower_wake_interrupt, 1'b0, "wake interrupt cleared");
      repeat (60) @(posedge pclk);
      apb(1'b0, A_US);
      check_rng((rd[9:0] + 10'd625 - v0[9:0]) % 625, 1, 6, "usec resumes");
      apb(1'b0, A_ST);
      check(rd & 32'h2, 32'h2, "woke status");
      $display("t_sleep_soft done");
   endtask

   task automatic t_ext();
      apb(1'b1, A_CTL, 32'h80000007);
      wait_deep(1'b1, 100);
      @(posedge pclk);
      ext_wake <= 1'b1;
      repeat (60) @(posedge pclk);
      check(deep_sleep_active, 1'b1, "ext wake disabled");
      apb(1'b1, A_CTL, 32'h00000007);
      wait_deep(1'b0, 20);
      ext_wake <= 1'b0;
      apb(1'b0, A_CTL);
      check(rd, 32'h3, "request cleared at ext wake");
      check(lowpower_wake_interrupt, 1'b1, "wake interrupt at ext wake");
      apb(1'b1, A_CTL, 32'hb);
      apb(1'b0, A_CTL);
      check(rd, 32'h3, "ctl after ext wake");
      $display("t_ext done");
   endtask

   task automatic t_duration();
      apb(1'b1, rts_pkg::OFS_SLEEP_SET, 32'h4);
      apb(1'b0, rts_pkg::OFS_SLEEP_SET);
      check(rd, 32'h4, "duration setting");
      apb(1'b1, A_CTL, 32'h7);
      wait_deep(1'b1, 100);
      wait_deep(1'b0, 200);
      apb(1'b0, A_MEAS);
      check_rng(rd, 3, 4, "measured at timed wake");
      apb(1'b0, A_CTL);
      check(rd, 32'h3, "request cleared at timed wake");
      apb(1'b1, rts_pkg::OFS_SLEEP_SET, 32'h0);
      apb(1'b1, A_CTL, 32'hb);
      $display("t_duration done");
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      ext_wake = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_regs();
      t_fine();
      t_base_irq();
      t_sleep_soft();
      t_ext();
      t_duration();
      wrap_up();
   end
endmodule
